// ==== pgap_core.sv ====
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "pgap_regs.svh"

module pgap_core #(
  parameter int PRI_BITS = 5
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  output logic                    err_o,
  // Grouping request and answer
  input  wire pgap_pkg::pgap_cls_s cls_i,
  output logic      [7:0]         grp_prio_o,
  // Priority store
  input  wire pgap_pkg::pgap_pwr_s pwr_i,
  output logic      [7:0]         stored_prio_o,
  // Acknowledge of a non-maskable interrupt
  input  wire logic               nmi_ack_i,
  input  wire logic               nmi_ack_sec_i,
  // Running priority
  output logic      [7:0]         running_prio_o,
  output logic                    nmi_active_sec_o,
  output logic                    nmi_active_ns_o
);

  // ----------------------------------------------------------------
  // Sizing
  // ----------------------------------------------------------------
  localparam int GBITS  = (PRI_BITS > 7) ? 7 : PRI_BITS;
  localparam int LEVELS = 1 << GBITS;
  localparam int NREG   = (GBITS == 7) ? 4 : (GBITS == 6) ? 2 : 1;
  localparam int PSHIFT = 8 - GBITS;
  localparam logic [2:0]   BP_MIN = 3'(7 - GBITS);
  localparam logic [127:0] LVL_MASK = (128'h1 << LEVELS) - 128'h1;
  // Non-secure levels are the upper half, so a non-secure write can
  // never clear or set a level that secure software relies on.
  localparam logic [127:0] NS_MASK  = LVL_MASK & ~(LVL_MASK >> (LEVELS / 2));

  logic [2:0]   bp0;
  logic [2:0]   bp1s;
  logic [2:0]   bp1ns;
  logic         scbpr;
  logic         nscbpr;
  logic         mscbpr;
  logic [127:0] ap0;
  logic [127:0] ap1s;
  logic [127:0] ap1ns;
  logic         req;
  logic         wr_commit;
  logic         hit;
  logic [31:0]  next_rdata;
  logic [1:0]   ap_idx;
  logic [2:0]   eff_bp;
  logic [31:0]  wmask;
  logic [7:0]   next_running;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Writes below the supported minimum land on the minimum.
  // minimum point clamp
  function automatic logic [2:0] bp_clamp(input logic [2:0] v);
    bp_clamp = (v < BP_MIN) ? BP_MIN : v;
  endfunction : bp_clamp

  function automatic logic [7:0] grp_mask(input logic [2:0] bp);
    grp_mask = 8'((9'h1fe << bp));
  endfunction : grp_mask

  // Active bank word, beyond implemented levels reads as zero.
  function automatic logic [31:0] ap_word(input logic [127:0] bank,
                                          input logic [1:0]   idx);
    ap_word = bank[32*idx +: 32] & LVL_MASK[32*idx +: 32];
  endfunction : ap_word

  assign req       = cyc_i & stb_i;
  assign wr_commit = req & we_i & ack_o;
  assign ap_idx    = adr_i[3:2];
  assign wmask     = {{8{sel_i[3]}}, {8{sel_i[2]}},
                      {8{sel_i[1]}}, {8{sel_i[0]}}};

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Undefined active indices take the bus error answer.
  always_comb begin
    next_rdata = 32'h0;
    hit        = 1'b1;
    case (adr_i & 8'hf0)
      `PGAP_AP0: begin
        hit        = (32'(ap_idx) < NREG);
        next_rdata = ap_word(ap0, ap_idx);
      end
      `PGAP_AP1S: begin
        hit        = (32'(ap_idx) < NREG);
        next_rdata = ap_word(ap1s, ap_idx);
      end
      `PGAP_AP1NS_SEC, `PGAP_AP1NS_NS: begin
        hit        = (32'(ap_idx) < NREG);
        next_rdata = ap_word(ap1ns, ap_idx);
      end
      default: begin
        case (adr_i)
          `PGAP_CTRL3: begin
            next_rdata[`PGAP_PRIB_LSB +: 3] = 3'(PRI_BITS - 1);
            next_rdata[`PGAP_SCBPR_BIT]     = scbpr;
            next_rdata[`PGAP_NSCBPR_BIT]    = nscbpr;
            next_rdata[`PGAP_MSCBPR_BIT]    = mscbpr;
          end
          `PGAP_CTRL1:
            next_rdata[`PGAP_PRIB_LSB +: 3] = 3'(PRI_BITS - 1);
          `PGAP_BP0:        next_rdata[2:0] = bp0;
          `PGAP_BP1_S:      next_rdata[2:0] = scbpr ? bp0 : bp1s;
          `PGAP_BP1_NS: begin
            if (nscbpr) begin
              next_rdata[2:0] = (bp0 == `PGAP_BP_MAX) ? `PGAP_BP_MAX
                                                      : bp0 + 3'h1;
            end else begin
              next_rdata[2:0] = bp1ns;
            end
          end
          `PGAP_BP1_S_EL3:  next_rdata[2:0] = bp1s;
          `PGAP_BP1_NS_EL3: next_rdata[2:0] = bp1ns;
          `PGAP_BP1_32_EL3: next_rdata[2:0] = mscbpr ? bp0 : bp1s;
          `PGAP_NMI: begin
            next_rdata[`PGAP_NMI_S_BIT]  = nmi_active_sec_o;
            next_rdata[`PGAP_NMI_NS_BIT] = nmi_active_ns_o;
          end
          default: hit = 1'b0;
        endcase
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // One wait state: data and answer are latched together.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req & ~ack_o & ~err_o & hit;
      err_o <= req & ~ack_o & ~err_o & ~hit;
      if (req & ~ack_o & ~err_o) begin
        dat_o <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control selects
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scbpr  <= 1'b0;
      nscbpr <= 1'b0;
      mscbpr <= 1'b0;
    end else if (wr_commit && adr_i == `PGAP_CTRL3 && sel_i[0]) begin
      scbpr  <= dat_i[`PGAP_SCBPR_BIT];
      nscbpr <= dat_i[`PGAP_NSCBPR_BIT];
      mscbpr <= dat_i[`PGAP_MSCBPR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Binary points
  // ----------------------------------------------------------------
  // Secure aliased group-1 writes land in group 0 through one process.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bp0   <= BP_MIN;
      bp1s  <= BP_MIN;
      bp1ns <= BP_MIN + 3'h1;
    end else if (wr_commit && sel_i[0]) begin
      case (adr_i)
        `PGAP_BP0:        bp0 <= bp_clamp(dat_i[2:0]);
        `PGAP_BP1_S: begin
          if (scbpr) begin
            bp0 <= bp_clamp(dat_i[2:0]);
          end else begin
            bp1s <= bp_clamp(dat_i[2:0]);
          end
        end
        `PGAP_BP1_NS: begin
          if (!nscbpr) begin
            bp1ns <= bp_clamp(dat_i[2:0]);
          end
        end
        `PGAP_BP1_S_EL3:  bp1s  <= bp_clamp(dat_i[2:0]);
        `PGAP_BP1_NS_EL3: bp1ns <= bp_clamp(dat_i[2:0]);
        `PGAP_BP1_32_EL3: begin
          if (mscbpr) begin
            bp0 <= bp_clamp(dat_i[2:0]);
          end else begin
            bp1s <= bp_clamp(dat_i[2:0]);
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Active priority banks
  // ----------------------------------------------------------------
  // Each write takes effect at its own answer edge, so a restore
  // sequence needs no barrier between words.
  // bank writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ap0   <= 128'h0;
      ap1s  <= 128'h0;
      ap1ns <= 128'h0;
    end else if (wr_commit) begin
      case (adr_i & 8'hf0)
        `PGAP_AP0:
          ap0[32*ap_idx +: 32] <= (ap0[32*ap_idx +: 32] & ~wmask)
                                | (dat_i & wmask);
        `PGAP_AP1S:
          ap1s[32*ap_idx +: 32] <= (ap1s[32*ap_idx +: 32] & ~wmask)
                                 | (dat_i & wmask);
        `PGAP_AP1NS_SEC:
          ap1ns[32*ap_idx +: 32] <= (ap1ns[32*ap_idx +: 32] & ~wmask)
                                  | (dat_i & wmask);
        `PGAP_AP1NS_NS:
          ap1ns[32*ap_idx +: 32] <= (ap1ns[32*ap_idx +: 32]
                                    & ~(wmask & NS_MASK[32*ap_idx +: 32]))
                                  | (dat_i & wmask
                                    & NS_MASK[32*ap_idx +: 32]);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Non-maskable active flags
  // ----------------------------------------------------------------
  // An acknowledge in the clearing cycle wins over the clear.
  // set on acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_active_sec_o <= 1'b0;
      nmi_active_ns_o  <= 1'b0;
    end else begin
      if (wr_commit && adr_i == `PGAP_NMI && sel_i[0]) begin
        nmi_active_sec_o <= dat_i[`PGAP_NMI_S_BIT];
        nmi_active_ns_o  <= dat_i[`PGAP_NMI_NS_BIT];
      end
      if (nmi_ack_i && nmi_ack_sec_i) begin
        nmi_active_sec_o <= 1'b1;
      end
      if (nmi_ack_i && !nmi_ack_sec_i) begin
        nmi_active_ns_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Group priority
  // ----------------------------------------------------------------
  // point source select
  always_comb begin
    case (cls_i.grp)
      pgap_pkg::PGAP_G0:   eff_bp = bp0;
      pgap_pkg::PGAP_G1S:  eff_bp = scbpr ? bp0 : bp1s;
      // stored minus one; stored zero reads as zero
      default: begin
        if (nscbpr) begin
          eff_bp = bp0;
        end else begin
          eff_bp = (bp1ns == 3'h0) ? 3'h0 : bp1ns - 3'h1;
        end
      end
    endcase
  end

  // Grouping works on the full stored value, never a shifted view.
  // apply mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grp_prio_o <= 8'h0;
    end else begin
      grp_prio_o <= cls_i.prio & grp_mask(eff_bp);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stored_prio_o <= 8'h0;
    end else if (pwr_i.valid) begin
      stored_prio_o <= pwr_i.prio;
      if (pwr_i.nonsecure) begin
        stored_prio_o[`PGAP_NS_PRIO_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Running priority
  // ----------------------------------------------------------------
  // Lowest set bit is the highest active level; none means idle.
  // lowest active bit
  always_comb begin
    logic [127:0] act;
    act          = (ap0 | ap1s | ap1ns) & LVL_MASK;
    next_running = `PGAP_IDLE_PRIO;
    for (int i = 127; i >= 0; i--) begin
      if (act[i]) begin
        next_running = 8'(i << PSHIFT);
      end
    end
  end

  // Registered so the output is a clean flop, one cycle behind banks.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running_prio_o <= `PGAP_IDLE_PRIO;
    end else begin
      running_prio_o <= next_running;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_new_req;
    req && !ack_o && !err_o;
  endsequence

  sequence s_ns_ap_write;
    wr_commit && (adr_i & 8'hf0) == `PGAP_AP1NS_NS;
  endsequence

  a_ns_bp_minus: assert property (
    cls_i.grp == pgap_pkg::PGAP_G1NS && !nscbpr && bp1ns == 3'h2
    |=> grp_prio_o == ($past(cls_i.prio) & 8'hfc))
    else $error("Non-secure point not reduced by one.");

  a_g0_bp_seven: assert property (
    cls_i.grp == pgap_pkg::PGAP_G0 && bp0 == 3'h7
    |=> grp_prio_o == 8'h0)
    else $error("Point seven must leave no group bits.");

  a_mask_low_bit: assert property (
    grp_prio_o[0] == 1'b0)
    else $error("Group priority bit zero must be clear.");

  a_sec_alias_wr: assert property (
    wr_commit && sel_i[0] && adr_i == `PGAP_BP1_S && scbpr
    && dat_i[2:0] >= BP_MIN
    |=> bp0 == $past(dat_i[2:0]) && $stable(bp1s))
    else $error("Secure alias write missed group 0.");

  a_ns_bp_ignore: assert property (
    wr_commit && adr_i == `PGAP_BP1_NS && nscbpr |=> $stable(bp1ns))
    else $error("Non-secure point changed under common select.");

  a_undef_err: assert property (
    s_new_req ##0 ((adr_i & 8'hf0) == `PGAP_AP0
                   && 32'(ap_idx) >= NREG)
    |=> err_o && !ack_o)
    else $error("Undefined active index was not refused.");

  a_ns_ap_guard: assert property (
    s_ns_ap_write |=> (ap1ns & ~NS_MASK) == $past(ap1ns & ~NS_MASK))
    else $error("Non-secure write reached secure range.");

  a_nmi_set: assert property (
    nmi_ack_i && nmi_ack_sec_i |=> nmi_active_sec_o)
    else $error("Acknowledge did not set the flag.");

  a_idle_empty: assert property (
    ap0 == 128'h0 && ap1s == 128'h0 && ap1ns == 128'h0
    |=> running_prio_o == `PGAP_IDLE_PRIO)
    else $error("Empty banks must show idle priority.");

  a_ns_force7: assert property (
    pwr_i.valid && pwr_i.nonsecure |=> stored_prio_o[7])
    else $error("Non-secure priority bit seven not set.");

  a_bus_answer: assert property (
    s_new_req |=> (ack_o ^ err_o) ##1 (!ack_o && !err_o))
    else $error("Bus answer not one cycle wide.");

endmodule : pgap_core
`default_nettype wire

// ==== pgap_regs.svh ====
// How it works
// - Non-secure group 1 uses stored point minus one
// - Point n splits group [7:n+1], sub [n:0]
// - Group priority is priority ANDed with mask
// - Point source chosen by group and selects
// - Minimum point set by implemented priority bits
// - Priority bit count readable in both controls
// - Secure common select aliases group1 onto group0
// - Non-secure common select ignores writes, reads plus one
// - Grouping uses the full stored priority
// - Non-monitor 32-bit view aliases group0 when selected
// - Active registers 1-3 undefined at 32 levels
// - Active registers 2-3 undefined below 65 levels
// - All-zero active registers mean nothing active
// - Separate non-maskable active flags, set on acknowledge
// - Non-secure writes cannot touch secure active range
// - Back-to-back active writes need no barrier
// - Active banks sized by group priority bits
// - Non-secure priority writes force bit 7 high
// - Running priority is highest active group priority
`ifndef PGAP_REGS_SVH
`define PGAP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PGAP_CTRL3       8'h00
`define PGAP_CTRL1       8'h04
`define PGAP_BP0         8'h10
`define PGAP_BP1_S       8'h14
`define PGAP_BP1_NS      8'h18
`define PGAP_BP1_S_EL3   8'h1c
`define PGAP_BP1_NS_EL3  8'h20
`define PGAP_BP1_32_EL3  8'h24
`define PGAP_AP0         8'h40
`define PGAP_AP1S        8'h50
`define PGAP_AP1NS_SEC   8'h60
`define PGAP_AP1NS_NS    8'h70
`define PGAP_NMI         8'h80

// ----------------------------------------------------------------
// Fields and constants
// ----------------------------------------------------------------
`define PGAP_SCBPR_BIT   0
`define PGAP_NSCBPR_BIT  1
`define PGAP_MSCBPR_BIT  2
`define PGAP_PRIB_LSB    8
`define PGAP_NMI_S_BIT   0
`define PGAP_NMI_NS_BIT  1
`define PGAP_BP_MAX      3'h7
`define PGAP_IDLE_PRIO   8'hff
`define PGAP_NS_PRIO_BIT 7

`endif

// ==== pgap_pkg.sv ====
`default_nettype none
// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package pgap_pkg;
  typedef enum logic [1:0] {
    PGAP_G0,
    PGAP_G1S,
    PGAP_G1NS
  } pgap_grp_e;

  // Interrupt whose group priority is wanted.
  typedef struct packed {
    logic [7:0] prio;
    pgap_grp_e  grp;
  } pgap_cls_s;

  // Priority write from the configuration side.
  typedef struct packed {
    logic       valid;
    logic       nonsecure;
    logic [7:0] prio;
  } pgap_pwr_s;
endpackage : pgap_pkg
`default_nettype wire

// ==== pgap_pe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Processing element acknowledging non-maskable interrupts
// ----------------------------------------------------------------
module pgap_pe_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Request from the bench
  input  wire logic take_i,
  input  wire logic sec_i,
  // Acknowledge towards the block
  output logic      ack_o,
  output logic      ack_sec_o
);
  // One pulse per take; the security line toggles while idle so that a
  // stale level can never pass for a qualifier.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o     <= 1'b0;
      ack_sec_o <= 1'b0;
    end else begin
      ack_o     <= take_i;
      ack_sec_o <= take_i ? sec_i : ~ack_sec_o;
    end
  end
endmodule : pgap_pe_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pgap_regs.svh"
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                cyc_i = 1'b0;
  logic                stb_i = 1'b0;
  logic                we_i  = 1'b0;
  logic [7:0]          adr_i = 8'h00;
  logic [3:0]          sel_i = 4'h0;
  logic [31:0]         dat_i = 32'h0;
  pgap_pkg::pgap_cls_s cls_i = '0;
  pgap_pkg::pgap_pwr_s pwr_i = '0;
  logic                take  = 1'b0;
  logic                tsec  = 1'b0;
  logic [31:0]         dat_o;
  logic                ack_o, err_o, nmi_ack_i, nmi_ack_sec_i;
  logic [7:0]          grp_prio_o, stored_prio_o, running_prio_o;
  logic                nmi_active_sec_o, nmi_active_ns_o;
  logic [31:0]         rd;
  logic                re;
  int                  err_count = 0;
  int                  n_checks  = 0;

  // Free-running 40 MHz clock.
  always #12.5 clk_i = ~clk_i;

  pgap_core #(.PRI_BITS(5)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .cls_i(cls_i),
    .grp_prio_o(grp_prio_o), .pwr_i(pwr_i),
    .stored_prio_o(stored_prio_o), .nmi_ack_i(nmi_ack_i),
    .nmi_ack_sec_i(nmi_ack_sec_i), .running_prio_o(running_prio_o),
    .nmi_active_sec_o(nmi_active_sec_o),
    .nmi_active_ns_o(nmi_active_ns_o));

  pgap_pe_model u_pe (
    .clk_i(clk_i), .rst_i(rst_i), .take_i(take), .sec_i(tsec),
    .ack_o(nmi_ack_i), .ack_sec_o(nmi_ack_sec_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle; the answer is taken at the edge where it is seen.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
    rd = dat_o;
    re = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) begin
      err_count++;
      $display("CHECK FAILED t=%0t bus answer missing", $time);
    end
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic erc(input logic w, input logic [7:0] a);
    bus(w, a, 32'hffff_ffff);
    chk({31'h0, re}, 32'h1);
  endtask : erc

  task automatic settle();
    repeat (2) @(posedge clk_i);
  endtask : settle

  task automatic grp(input logic [7:0] p, input pgap_pkg::pgap_grp_e g,
                     input logic [7:0] exp);
    @(posedge clk_i);
    cls_i <= '{prio: p, grp: g};
    settle();
    chk({24'h0, grp_prio_o}, {24'h0, exp});
  endtask : grp

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(`PGAP_BP0, 32'h2);
    rdc(`PGAP_BP1_NS, 32'h3);
    rdc(`PGAP_CTRL1, 32'h400);
    rdc(`PGAP_CTRL3, 32'h400);
    chk({24'h0, running_prio_o}, 32'hff);
    erc(1'b0, 8'hfc);
  endtask : t_reset

  task automatic t_group();
    grp(8'hab, pgap_pkg::PGAP_G0, 8'ha8);
    bus(1'b1, `PGAP_BP0, 32'h0);
    rdc(`PGAP_BP0, 32'h2);
    bus(1'b1, `PGAP_BP0, 32'h4);
    grp(8'hab, pgap_pkg::PGAP_G0, 8'ha0);
    bus(1'b1, `PGAP_BP0, 32'h7);
    grp(8'hab, pgap_pkg::PGAP_G0, 8'h00);
    grp(8'hab, pgap_pkg::PGAP_G1NS, 8'ha8);
    bus(1'b1, `PGAP_BP1_NS, 32'h2);
    grp(8'hff, pgap_pkg::PGAP_G1NS, 8'hfc);
    bus(1'b1, `PGAP_BP1_NS, 32'h7);
    grp(8'hab, pgap_pkg::PGAP_G1NS, 8'h80);
    grp(8'hab, pgap_pkg::PGAP_G1S, 8'ha8);
    bus(1'b1, `PGAP_BP1_S, 32'h6);
    grp(8'hab, pgap_pkg::PGAP_G1S, 8'h80);
  endtask : t_group

  task automatic t_common();
    bus(1'b1, `PGAP_CTRL3, 32'h1);
    bus(1'b1, `PGAP_BP1_S, 32'h4);
    rdc(`PGAP_BP0, 32'h4);
    rdc(`PGAP_BP1_S, 32'h4);
    rdc(`PGAP_BP1_S_EL3, 32'h6);
    grp(8'hab, pgap_pkg::PGAP_G1S, 8'ha0);
    bus(1'b1, `PGAP_CTRL3, 32'h3);
    bus(1'b1, `PGAP_BP1_NS, 32'h3);
    rdc(`PGAP_BP1_NS, 32'h5);
    rdc(`PGAP_BP1_NS_EL3, 32'h7);
    grp(8'hab, pgap_pkg::PGAP_G1NS, 8'ha0);
    bus(1'b1, `PGAP_BP0, 32'h7);
    rdc(`PGAP_BP1_NS, 32'h7);
    bus(1'b1, `PGAP_CTRL3, 32'h4);
    bus(1'b1, `PGAP_BP1_32_EL3, 32'h3);
    rdc(`PGAP_BP0, 32'h3);
    bus(1'b1, `PGAP_CTRL3, 32'h0);
  endtask : t_common

  task automatic t_active();
    bus(1'b1, `PGAP_AP0, 32'h100);
    bus(1'b1, `PGAP_AP1S, 32'h40);
    bus(1'b1, `PGAP_AP1NS_SEC, 32'h4);
    settle();
    chk({24'h0, running_prio_o}, 32'h10);
    rdc(`PGAP_AP0, 32'h100);
    rdc(`PGAP_AP1S, 32'h40);
    rdc(`PGAP_AP1NS_SEC, 32'h4);
    bus(1'b1, `PGAP_AP0, 32'h0);
    bus(1'b1, `PGAP_AP1S, 32'h0);
    bus(1'b1, `PGAP_AP1NS_SEC, 32'h0);
    settle();
    chk({24'h0, running_prio_o}, 32'hff);
    bus(1'b1, `PGAP_AP1NS_NS, 32'hffff_ffff);
    settle();
    chk({24'h0, running_prio_o}, 32'h80);
    rdc(`PGAP_AP1NS_SEC, 32'hffff_0000);
    bus(1'b1, `PGAP_AP1NS_NS, 32'h0);
    settle();
    chk({24'h0, running_prio_o}, 32'hff);
    erc(1'b1, `PGAP_AP0 + 8'h04);
    erc(1'b0, `PGAP_AP1S + 8'h0c);
    rdc(`PGAP_AP0, 32'h0);
  endtask : t_active

  task automatic t_nmi();
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk_i);
      take <= 1'b1;
      tsec <= s[0];
      @(posedge clk_i);
      take <= 1'b0;
      settle();
      chk({31'h0, nmi_active_ns_o}, 32'h1 - s);
      chk({31'h0, nmi_active_sec_o}, 32'h1);
    end
    rdc(`PGAP_NMI, 32'h3);
    bus(1'b1, `PGAP_NMI, 32'h0);
    rdc(`PGAP_NMI, 32'h0);
  endtask : t_nmi

  task automatic t_prio();
    for (int ns = 0; ns < 2; ns++) begin
      @(posedge clk_i);
      pwr_i <= '{valid: 1'b1, nonsecure: ns[0], prio: 8'h12};
      @(posedge clk_i);
      pwr_i.valid <= 1'b0;
      settle();
      chk({24'h0, stored_prio_o}, ns ? 32'h92 : 32'h12);
    end
  endtask : t_prio

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_group();
    t_common();
    t_active();
    t_nmi();
    t_prio();
    end_of_test();
  end

  // The tests need well under 2000 cycles; 20000 means a hang.
  initial begin
    #500000;
    err_count++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
